// ===== ahpt_pkg.sv
// Shared constants and types for the alert and hot-pin timer block
package ahpt_pkg;
	// Register offsets
	localparam logic [7:0] STAT_ONE_ADDR = 8'h41;
	localparam logic [7:0] STAT_TWO_ADDR = 8'h42;
	localparam logic [7:0] MASK_ONE_ADDR = 8'h74;
	localparam logic [7:0] MASK_TWO_ADDR = 8'h75;
	localparam logic [7:0] CFG_THREE_ADDR = 8'h78;
	localparam logic [7:0] HOT_TIMER_ADDR = 8'h79;
	localparam logic [7:0] HOT_LIMIT_ADDR = 8'h7A;
	localparam logic [7:0] CFG_FOUR_ADDR = 8'h7D;
	// Reset values
	localparam logic [7:0] MASK_RESET = 8'h00;
	localparam logic [7:0] CFG_RESET = 8'h00;
	localparam logic [7:0] LIMIT_RESET = 8'h00;
	// Implemented status bits; bit 7 of the first register is derived
	localparam logic [7:0] STAT_ONE_USED = 8'h75;
	localparam logic [7:0] STAT_TWO_USED = 8'hFE;
	// Field positions
	localparam int ANY_SECOND_STATUS_BIT = 7;
	localparam int FOURTH_FAN_OR_TIMER_BIT = 5;
	localparam int CFG3_ALERT_BIT = 0;
	localparam int CFG3_HOT_EN_BIT = 1;
	localparam int CFG3_FULL_SPEED_OVERRIDE_BIT = 2;
	localparam int CFG4_ALT_ALERT_BIT = 0;
	// Timing
	localparam int CLK_PERIOD_NS = 100;
	localparam int HOT_LSB_NS = 22760000;
	localparam int HOT_LSB_CYCLES = HOT_LSB_NS / CLK_PERIOD_NS;
	localparam int HOT_SUB_W = 18;
	localparam logic [7:0] TIMER_FULL = 8'hFF;
	localparam int FAN_COUNT = 3;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} ahpt_reg_req_t;
endpackage

// ===== ahpt_hot_timer.sv
// Cumulative hot-pin assertion timer, saturating and cleared on read
`timescale 1ns/1ps
`default_nettype none
module ahpt_hot_timer #(
	parameter int TickCycles = ahpt_pkg::HOT_LSB_CYCLES
) (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic hotActive,
	input wire logic clearRd,
	output logic [7:0] timerValue
);
	import ahpt_pkg::*;

	logic [HOT_SUB_W-1:0] sub_r;
	logic [7:0] units_r;
	logic seen_r;
	wire tickDone = hotActive && (sub_r == HOT_SUB_W'(TickCycles - 1));
	wire unitsFull = (units_r == TIMER_FULL);

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			sub_r <= '0;
			units_r <= 8'h00;
			seen_r <= 1'b0;
		end else if (clearRd) begin
			// Read during assertion restarts from zero with bit 0 set
			sub_r <= '0;
			units_r <= 8'h00;
			seen_r <= hotActive;
		end else if (hotActive) begin
			seen_r <= 1'b1;
			if (tickDone) begin
				sub_r <= '0;
				if (!unitsFull) begin
					units_r <= units_r + 8'h01;
				end
			end else if (!unitsFull) begin
				sub_r <= sub_r + HOT_SUB_W'(1);
			end
		end
	end

	// Below two full periods only the first-assertion bit shows
	assign timerValue = (units_r >= 8'h02) ? units_r : {7'h00, seen_r};

	a_first_assert: assert property (@(posedge ref_clk) disable iff (!arst_n)
		(hotActive && !clearRd && timerValue == 8'h00) |=> timerValue == 8'h01)
		else $error("timer bit 0 not set on first assertion");
	a_timer_pause: assert property (@(posedge ref_clk) disable iff (!arst_n)
		(!hotActive && !clearRd) |=> $stable(timerValue) && $stable(units_r))
		else $error("timer moved while hot input negated");
	a_timer_saturate: assert property (@(posedge ref_clk) disable iff (!arst_n)
		(timerValue == 8'hFF && !clearRd) |=> timerValue == 8'hFF)
		else $error("timer left full scale without a read");
	a_read_restart: assert property (@(posedge ref_clk) disable iff (!arst_n)
		(clearRd && hotActive) |=> timerValue == 8'h01 && sub_r == '0)
		else $error("timer read during assertion did not restart at 1");
	a_read_clear: assert property (@(posedge ref_clk) disable iff (!arst_n)
		(clearRd && !hotActive) |=> timerValue == 8'h00)
		else $error("timer not cleared by read");
endmodule
`default_nettype wire

// ===== ahpt_alert_top.sv
// Sticky status, alert masking and routing, hot-pin full_speed_override and timer limit
// Operation
// - Out-of-limit condition sets its status bit; held until gone and status read.
// - Alert stays low while unmasked fault persists, then until status read.
// - A mask bit blocks only the alert; the status bit still sets.
// - First mask: 7 all second-register, 6 remote two, 5 local, 4 remote one, 2 supply, 0 2.5V.
// - Second mask: 7,6 diode faults, 5 fan four or timer, 4..2 fans, 1 overtemp.
// - Alert off after reset; config four bit 0 or config three bit 0 route it.
// - Config three bit 1 turns the shared pin into the hot input.
// - With full_speed_override set, running fans go full duty while hot pin is low.
// - Full_speed_override leaves fans that are stopped untouched.
// - Timer runs while hot input asserted, pauses otherwise, accumulating.
// - Timer clears on read and holds at full scale.
// - Bit 0 sets on first assertion; above 45.52 ms counts in 22.76 ms steps.
// - Read during assertion restarts at one; limit zero then sets timer flag.
// - Timer above limit sets second-status bit 5 and alerts unless masked.
// - Limit is eight bits on the timer's own scaling, up to 5.804 s.
// - Limit zero alerts on first assertion, limit one after 45.52 ms.
// - A status read clears a bit only if its condition has gone.
// - First status bit 7 reads one while any second status bit is set.
`timescale 1ns/1ps
`default_nettype none
module ahpt_alert_top #(
	parameter int TickCycles = ahpt_pkg::HOT_LSB_CYCLES
) (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire ahpt_pkg::ahpt_reg_req_t regReq,
	output logic [7:0] regRdData,
	input wire logic [7:0] statCondOne,
	input wire logic [7:0] statCondTwo,
	input wire logic hotPin_n,
	input wire logic [ahpt_pkg::FAN_COUNT-1:0] fanRunning,
	output logic [ahpt_pkg::FAN_COUNT-1:0] fanFullSpeed,
	output logic alertMain_n,
	output logic alertOnAltPin_n
);
	import ahpt_pkg::*;

	logic [7:0] statOne_r;
	logic [7:0] statTwo_r;
	logic [7:0] maskOne_r;
	logic [7:0] maskTwo_r;
	logic [7:0] cfgThree_r;
	logic [7:0] cfgFour_r;
	logic [7:0] hotLimit_r;
	logic hotSyncA_r;
	logic hotSyncB_r;
	logic [7:0] timerValue;

	// Register decode
	wire wrMaskOne = regReq.wr && regReq.addr == MASK_ONE_ADDR;
	wire wrMaskTwo = regReq.wr && regReq.addr == MASK_TWO_ADDR;
	wire wrCfgThree = regReq.wr && regReq.addr == CFG_THREE_ADDR;
	wire wrCfgFour = regReq.wr && regReq.addr == CFG_FOUR_ADDR;
	wire wrLimit = regReq.wr && regReq.addr == HOT_LIMIT_ADDR;
	wire rdStatOne = regReq.rd && regReq.addr == STAT_ONE_ADDR;
	wire rdStatTwo = regReq.rd && regReq.addr == STAT_TWO_ADDR;
	wire rdTimer = regReq.rd && regReq.addr == HOT_TIMER_ADDR;

	// Configuration fields
	wire alertMainEn = cfgThree_r[CFG3_ALERT_BIT];
	wire alertAltEn = cfgFour_r[CFG4_ALT_ALERT_BIT];
	wire hotEnable = cfgThree_r[CFG3_HOT_EN_BIT];
	wire boostEnable = cfgThree_r[CFG3_FULL_SPEED_OVERRIDE_BIT];

	// Hot pin is asynchronous and active low; gated by its enable
	wire hotActive = hotEnable && !hotSyncB_r;

	// Timer above limit; limit zero trips on the first assertion
	wire timerOver = timerValue > hotLimit_r;

	// With the hot input in use, bit 5 reports the timer instead of fan four
	wire [7:0] condTwo;
	assign condTwo = {statCondTwo[7:6],
		hotEnable ? timerOver : statCondTwo[FOURTH_FAN_OR_TIMER_BIT],
		statCondTwo[4:0]} & STAT_TWO_USED;
	wire [7:0] condOne = statCondOne & STAT_ONE_USED;

	// Sticky update: a live condition always wins over a read clear
	wire [7:0] statOneNxt = (statOne_r & ~(rdStatOne ? ~condOne : 8'h00)) | condOne;
	wire [7:0] statTwoNxt = (statTwo_r & ~(rdStatTwo ? ~condTwo : 8'h00)) | condTwo;

	// Summary bit is derived, never stored, so it can never go stale
	wire anySecondStatusFlag = |statTwo_r;
	wire [7:0] statOneView;
	assign statOneView = {anySecondStatusFlag, statOne_r[6:0]};

	// Masks gate only the alert path, not the status bits
	wire firstPending = |(statOne_r & ~maskOne_r & STAT_ONE_USED);
	wire secondPending = !maskOne_r[ANY_SECOND_STATUS_BIT]
		&& |(statTwo_r & ~maskTwo_r & STAT_TWO_USED);
	wire alertRequest = firstPending || secondPending;

	// Read mux; unmapped offsets answer zero
	wire [7:0] rdMux;
	assign rdMux =
		(regReq.addr == STAT_ONE_ADDR) ? statOneView :
		(regReq.addr == STAT_TWO_ADDR) ? statTwo_r :
		(regReq.addr == MASK_ONE_ADDR) ? maskOne_r :
		(regReq.addr == MASK_TWO_ADDR) ? maskTwo_r :
		(regReq.addr == CFG_THREE_ADDR) ? cfgThree_r :
		(regReq.addr == HOT_TIMER_ADDR) ? timerValue :
		(regReq.addr == HOT_LIMIT_ADDR) ? hotLimit_r :
		(regReq.addr == CFG_FOUR_ADDR) ? cfgFour_r : 8'h00;

	// Full_speed_override only lifts fans that are already spinning
	wire [FAN_COUNT-1:0] boostNxt;
	genvar fanIdx;
	generate
		for (fanIdx = 0; fanIdx < FAN_COUNT; fanIdx++) begin : gFan
			assign boostNxt[fanIdx] = boostEnable && hotActive && fanRunning[fanIdx];
		end
	endgenerate

	ahpt_hot_timer #(
		.TickCycles(TickCycles)
	) uTimer (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.hotActive(hotActive),
		.clearRd(rdTimer),
		.timerValue(timerValue)
	);

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			hotSyncA_r <= 1'b1;
			hotSyncB_r <= 1'b1;
		end else begin
			hotSyncA_r <= hotPin_n;
			hotSyncB_r <= hotSyncA_r;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			statOne_r <= 8'h00;
			statTwo_r <= 8'h00;
		end else begin
			statOne_r <= statOneNxt;
			statTwo_r <= statTwoNxt;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			maskOne_r <= MASK_RESET;
			maskTwo_r <= MASK_RESET;
			cfgThree_r <= CFG_RESET;
			cfgFour_r <= CFG_RESET;
			hotLimit_r <= LIMIT_RESET;
		end else begin
			if (wrMaskOne) begin
				maskOne_r <= regReq.wdata;
			end
			if (wrMaskTwo) begin
				maskTwo_r <= regReq.wdata;
			end
			if (wrCfgThree) begin
				cfgThree_r <= regReq.wdata;
			end
			if (wrCfgFour) begin
				cfgFour_r <= regReq.wdata;
			end
			if (wrLimit) begin
				hotLimit_r <= regReq.wdata;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			regRdData <= 8'h00;
			alertMain_n <= 1'b1;
			alertOnAltPin_n <= 1'b1;
			fanFullSpeed <= '0;
		end else begin
			if (regReq.rd) begin
				regRdData <= rdMux;
			end
			alertMain_n <= !(alertMainEn && alertRequest);
			alertOnAltPin_n <= !(alertAltEn && alertRequest);
			fanFullSpeed <= boostNxt;
		end
	end

	a_status_sets: assert property (@(posedge ref_clk) disable iff (!arst_n)
		(condOne != 8'h00) |=> ((statOne_r & $past(condOne)) == $past(condOne)))
		else $error("first status missed a live condition");
	a_read_clears: assert property (@(posedge ref_clk) disable iff (!arst_n)
		(rdStatTwo && condTwo == 8'h00) |=> statTwo_r == 8'h00)
		else $error("second status not cleared by read after fault gone");
	a_sticky_hold: assert property (@(posedge ref_clk) disable iff (!arst_n)
		(!rdStatOne && statOne_r != 8'h00) |=> ((statOne_r & $past(statOne_r)) == $past(statOne_r)))
		else $error("status bit dropped without a read");
	a_alert_follows: assert property (@(posedge ref_clk) disable iff (!arst_n)
		(alertMainEn && firstPending) |=> !alertMain_n)
		else $error("alert not asserted for unmasked status");
	a_mask_blocks: assert property (@(posedge ref_clk) disable iff (!arst_n)
		((statOne_r & ~maskOne_r & STAT_ONE_USED) == 8'h00
		&& (maskOne_r[ANY_SECOND_STATUS_BIT]
		|| (statTwo_r & ~maskTwo_r & STAT_TWO_USED) == 8'h00))
		|=> alertMain_n && alertOnAltPin_n)
		else $error("fully masked source drove the alert");
	a_alert_disabled: assert property (@(posedge ref_clk) disable iff (!arst_n)
		(!alertAltEn) |=> alertOnAltPin_n)
		else $error("alternate alert pin driven while disabled");
	a_summary_bit: assert property (@(posedge ref_clk) disable iff (!arst_n)
		(rdStatOne && statTwo_r != 8'h00) |=> regRdData[7])
		else $error("summary bit clear with second status set");
	a_full_speed_override_stopped: assert property (@(posedge ref_clk) disable iff (!arst_n)
		(fanRunning == '0) |=> fanFullSpeed == '0)
		else $error("full_speed_override drove a stopped fan");
	a_full_speed_override_running: assert property (@(posedge ref_clk) disable iff (!arst_n)
		(boostEnable && hotEnable && !hotSyncB_r)
		|=> (fanFullSpeed & $past(fanRunning)) == $past(fanRunning))
		else $error("full_speed_override missed running fans while hot");
	a_limit_flag: assert property (@(posedge ref_clk) disable iff (!arst_n)
		(hotEnable && timerValue > hotLimit_r) |=> statTwo_r[FOURTH_FAN_OR_TIMER_BIT])
		else $error("timer over limit did not set status bit 5");
	a_hot_sync: assert property (@(posedge ref_clk) disable iff (!arst_n)
		$past(arst_n, 2) |-> hotActive == (hotEnable && !$past(hotPin_n, 2)))
		else $error("hot input does not follow the enabled pin");
	a_alert_second: assert property (@(posedge ref_clk) disable iff (!arst_n)
		(alertMainEn && secondPending) |=> !alertMain_n)
		else $error("alert not asserted for unmasked second status");
	a_alt_follows: assert property (@(posedge ref_clk) disable iff (!arst_n)
		(alertAltEn && alertRequest) |=> !alertOnAltPin_n)
		else $error("alternate alert not asserted for pending source");
	a_alert_idle: assert property (@(posedge ref_clk) disable iff (!arst_n)
		(!alertMainEn) |=> alertMain_n)
		else $error("main alert driven while disabled");
	a_read_clears_one: assert property (@(posedge ref_clk) disable iff (!arst_n)
		(rdStatOne && condOne == 8'h00) |=> statOne_r == 8'h00)
		else $error("first status not cleared by read after fault gone");
	a_limit_stored: assert property (@(posedge ref_clk) disable iff (!arst_n)
		wrLimit |=> hotLimit_r == $past(regReq.wdata))
		else $error("limit register did not take the written value");
endmodule
`default_nettype wire

// ===== ahpt_host_model.sv
// Host side of the register port: one-cycle write and read strobes
`timescale 1ns/1ps
`default_nettype none
module ahpt_host_model (
	input wire logic ref_clk,
	input wire logic [7:0] regRdData,
	output var ahpt_pkg::ahpt_reg_req_t regReq
);
	import ahpt_pkg::*;
	initial regReq = '0;
	// Entered just after an edge; the strobe stands one full cycle
	// An idle edge follows, so a next call never re-raises in the same step
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		regReq = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge ref_clk);
		#10 regReq = '0;
		@(posedge ref_clk);
		#10;
	endtask
	// Data is registered at the taking edge, so it is read just after it
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		regReq = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge ref_clk);
		#10 d = regRdData;
		regReq = '0;
		@(posedge ref_clk);
		#10;
	endtask
endmodule
`default_nettype wire

// ===== alert_and_hot_pin_timer_tb.sv
// Self-checking bench for the alert and hot-pin timer block
`timescale 1ns/1ps
`default_nettype none
module alert_and_hot_pin_timer_tb;
	import ahpt_pkg::*;
	localparam int T = 10;
	logic ref_clk = 1'b0;
	logic arst_n = 1'b0;
	logic [7:0] condOne = 8'h00;
	logic [7:0] condTwo = 8'h00;
	logic hotPin_n = 1'b1;
	logic [2:0] fanRun = 3'h0;
	logic [2:0] fanFull;
	logic [7:0] rdData;
	logic [7:0] d;
	logic alertA_n;
	logic alertB_n;
	ahpt_reg_req_t req;
	integer fail_count = 0;
	integer checks = 0;
	integer seed = 3432;
	integer cyc = 0;
	integer acc = 0;
	integer i;
	integer n;
	logic [7:0] addrs [6] = '{MASK_ONE_ADDR, MASK_TWO_ADDR, CFG_THREE_ADDR, HOT_LIMIT_ADDR,
		CFG_FOUR_ADDR, 8'h50};
	ahpt_alert_top #(.TickCycles(T)) u_ahpt_alert_top (.ref_clk(ref_clk), .arst_n(arst_n),
		.regReq(req), .regRdData(rdData), .statCondOne(condOne), .statCondTwo(condTwo),
		.hotPin_n(hotPin_n), .fanRunning(fanRun), .fanFullSpeed(fanFull),
		.alertMain_n(alertA_n), .alertOnAltPin_n(alertB_n));
	ahpt_host_model u_ahpt_host_model (.ref_clk(ref_clk), .regRdData(rdData), .regReq(req));
	initial forever #50 ref_clk = ~ref_clk;
	task automatic results();
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fail_count = fail_count + 1;
			results();
		end
	end
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		checks = checks + 1;
		if (seen !== exp) begin
			fail_count = fail_count + 1;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic step(input integer k);
		repeat (k) @(posedge ref_clk);
		#10;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
		u_ahpt_host_model.rd(a, d);
		chk("register", d, exp);
	endtask
	// Timer model: one on first assertion, then whole LSB periods, saturating
	function automatic logic [7:0] tv(input integer a);
		if (a == 0) return 8'h00;
		if (a / T < 1) return 8'h01;
		if (a / T > 255) return 8'hFF;
		return 8'(a / T);
	endfunction
	task automatic hot(input integer k);
		hotPin_n = 1'b0;
		step(4);
		chk("fanFull", {5'h00, fanFull}, {5'h00, fanRun});
		step(k - 4);
		hotPin_n = 1'b1;
		acc = acc + k;
		step(4);
		chk("fanIdle", {5'h00, fanFull}, 8'h00);
	endtask
	initial begin
		step(8);
		arst_n = 1'b1;
		step(1);
		chk("alertOff", {6'h00, alertA_n, alertB_n}, 8'h03);
		for (i = 0; i < 6; i++) rdc(addrs[i], 8'h00);
		for (i = 0; i < 5; i++) begin
			n = $random(seed);
			u_ahpt_host_model.wr(addrs[i], n[7:0]);
			rdc(addrs[i], n[7:0]);
		end
		u_ahpt_host_model.wr(MASK_ONE_ADDR, 8'h00);
		u_ahpt_host_model.wr(MASK_TWO_ADDR, 8'h00);
		u_ahpt_host_model.wr(CFG_FOUR_ADDR, 8'h01);
		u_ahpt_host_model.wr(CFG_THREE_ADDR, 8'h01);
		condOne = 8'h20;
		step(3);
		chk("alertOn", {6'h00, alertA_n, alertB_n}, 8'h00);
		condOne = 8'h00;
		step(3);
		chk("alertHeld", {7'h00, alertA_n}, 8'h00);
		rdc(STAT_ONE_ADDR, 8'h20);
		step(2);
		chk("alertDone", {7'h00, alertA_n}, 8'h01);
		condOne = 8'h20;
		step(3);
		rdc(STAT_ONE_ADDR, 8'h20);
		rdc(STAT_ONE_ADDR, 8'h20);
		condOne = 8'h00;
		rdc(STAT_ONE_ADDR, 8'h20);
		rdc(STAT_ONE_ADDR, 8'h00);
		u_ahpt_host_model.wr(MASK_ONE_ADDR, 8'h20);
		condOne = 8'h20;
		step(3);
		chk("alertMasked", {7'h00, alertA_n}, 8'h01);
		condOne = 8'h00;
		rdc(STAT_ONE_ADDR, 8'h20);
		u_ahpt_host_model.wr(MASK_ONE_ADDR, 8'h00);
		condTwo = 8'h10;
		step(3);
		rdc(STAT_ONE_ADDR, 8'h80);
		u_ahpt_host_model.wr(MASK_ONE_ADDR, 8'h80);
		step(3);
		chk("alertSecond", {7'h00, alertA_n}, 8'h01);
		condTwo = 8'h00;
		rdc(STAT_TWO_ADDR, 8'h10);
		rdc(STAT_ONE_ADDR, 8'h00);
		u_ahpt_host_model.wr(MASK_ONE_ADDR, 8'h00);
		fanRun = 3'($random(seed));
		u_ahpt_host_model.wr(CFG_THREE_ADDR, 8'h07);
		u_ahpt_host_model.wr(HOT_LIMIT_ADDR, 8'h01);
		hot(12);
		chk("alertBelow", {7'h00, alertA_n}, 8'h01);
		hot(12);
		chk("alertLimit", {7'h00, alertA_n}, 8'h00);
		rdc(HOT_TIMER_ADDR, tv(acc));
		acc = 0;
		rdc(STAT_TWO_ADDR, 8'h20);
		rdc(STAT_TWO_ADDR, 8'h00);
		// Offsets of 3 and 2 cycles keep the sum clear of LSB boundaries
		hot(10 * (1 + ($random(seed) & 3)) + 3);
		hot(10 * (1 + ($random(seed) & 3)) + 2);
		rdc(HOT_TIMER_ADDR, tv(acc));
		acc = 0;
		hotPin_n = 1'b0;
		step(15);
		rdc(HOT_TIMER_ADDR, 8'h01);
		rdc(HOT_TIMER_ADDR, 8'h01);
		hotPin_n = 1'b1;
		step(4);
		rdc(HOT_TIMER_ADDR, 8'h01);
		hot(2700);
		rdc(HOT_TIMER_ADDR, tv(acc));
		rdc(HOT_TIMER_ADDR, 8'h00);
		acc = 0;
		rdc(STAT_TWO_ADDR, 8'h20);
		u_ahpt_host_model.wr(HOT_LIMIT_ADDR, 8'h00);
		u_ahpt_host_model.wr(MASK_TWO_ADDR, 8'h20);
		hot(6);
		chk("alertTimerMask", {7'h00, alertA_n}, 8'h01);
		rdc(STAT_TWO_ADDR, 8'h20);
		results();
	end
endmodule
`default_nettype wire
